// File: core/sbc_pkg.sv
// Constants and types of the standby mode control block
package sbc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_SYS_CTRL1 = 8'h38;
    localparam logic [7:0] IDX_CLK_STBY = 8'h39;
    localparam logic [7:0] IDX_WAKE_CTRL = 8'h3A;
    localparam logic [7:0] IDX_STATUS = 8'h3B;
    localparam logic [7:0] ADDR_SYS_CTRL1 = 8'(IDX_SYS_CTRL1 * 4);
    localparam logic [7:0] ADDR_CLK_STBY = 8'(IDX_CLK_STBY * 4);
    localparam logic [7:0] ADDR_WAKE_CTRL = 8'(IDX_WAKE_CTRL * 4);
    localparam logic [7:0] ADDR_STATUS = 8'(IDX_STATUS * 4);

    // system_control_first field positions
    localparam int SC1_STOP = 7;
    localparam int SC1_RELEASE_METHOD_BIT = 6;
    localparam int SC1_RETURN_MODE_BIT = 5;
    localparam int SC1_OUTEN = 4;
    localparam int SC1_WUT_LSB = 2;

    // clock_and_standby_control field positions
    localparam int SC2_XEN = 7;
    localparam int SC2_LF_OSC_ENABLE = 6;
    localparam int SC2_MAIN_CLOCK_SELECT = 5;
    localparam int SC2_IDLE = 4;
    localparam int SC2_TIMING_GEN_HALT_BIT = 2;

    // Values after reset
    localparam logic [7:0] SC1_RESET = 8'h00;
    localparam logic [7:0] SC2_RESET = 8'h80;
    localparam logic [3:0] WAKE_RESET = 4'h0;

    // Warm-up lengths in high-frequency clock cycles, one per select code
    localparam logic [17:0] WARM_CYC_00_DEF = 18'h30000;
    localparam logic [17:0] WARM_CYC_01_DEF = 18'h10000;
    localparam logic [17:0] WARM_CYC_10_DEF = 18'h0C000;
    localparam logic [17:0] WARM_CYC_11_DEF = 18'h04000;

    typedef enum logic [1:0] {
        SBC_RUN,
        SBC_STOP,
        SBC_WARM
    } sbc_state_t;

    typedef enum logic [2:0] {
        SBC_SEL_NONE,
        SBC_SEL_SC1,
        SBC_SEL_SC2,
        SBC_SEL_WAKE,
        SBC_SEL_STAT
    } sbc_sel_t;
endpackage

// File: core/sbc_standby_ctrl.sv
// Standby mode, oscillator and deep-stop control with an APB register slave
//
// Implementation choice: register access over APB.
`timescale 1ns/100ps

// Operation
// - Control register resets to oscillator high only
// - Illegal oscillator disable requests a system reset
// - Select bit chooses clock, reads clock used
// - CPU-halt bit stops CPU and watchdog
// - Timing-generator halt gates peripheral clocks
// - Bits 3, 1, 0 read undefined
// - CPU-halt bit clears on mode release
// - Timing-generator halt clears on mode release
// - Writing deep-stop start bit enters deep-stop
// - Deep-stop turns oscillators off, state held
// - Deep-stop entry clears prescaler and divider
// - Program counter held during deep-stop
// - Release-method bit selects level or edge
// - Level release: stop pin high, key low
// - Active release at request skips straight to warm-up
// - Stop pin low during warm-up ignored
// - Level mode effective after stop pin rise
// - Edge mode releases on stop pin rise
// - Warm-up length from two-bit select, then resume
// - Reset pin release returns to normal mode
module sbc_standby_ctrl #(
    parameter logic [17:0] WARM_CYC_00 = sbc_pkg::WARM_CYC_00_DEF,
    parameter logic [17:0] WARM_CYC_01 = sbc_pkg::WARM_CYC_01_DEF,
    parameter logic [17:0] WARM_CYC_10 = sbc_pkg::WARM_CYC_10_DEF,
    parameter logic [17:0] WARM_CYC_11 = sbc_pkg::WARM_CYC_11_DEF
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic stop_pin_port_n,
    input wire logic [3:0] key_wakeup_inputs,
    input wire logic idle_release,
    input wire logic tg_release,
    output logic hf_osc_enable,
    output logic lf_osc_enable,
    output logic main_clock_in_use,
    output logic cpu_halt,
    output logic wdt_halt,
    output logic timing_gen_halt,
    output logic core_halt,
    output logic prescaler_clear,
    output logic osc_reset_req
);
    import sbc_pkg::*;

    // ==========================================================
    // Register decode
    function automatic sbc_sel_t decode(input logic [7:0] addr);
        case (addr)
            ADDR_SYS_CTRL1: decode = SBC_SEL_SC1;
            ADDR_CLK_STBY: decode = SBC_SEL_SC2;
            ADDR_WAKE_CTRL: decode = SBC_SEL_WAKE;
            ADDR_STATUS: decode = SBC_SEL_STAT;
            default: decode = SBC_SEL_NONE;
        endcase
    endfunction

    function automatic logic [17:0] warm_len(input logic [1:0] code);
        case (code)
            2'h0: warm_len = WARM_CYC_00;
            2'h1: warm_len = WARM_CYC_01;
            2'h2: warm_len = WARM_CYC_10;
            default: warm_len = WARM_CYC_11;
        endcase
    endfunction

    sbc_state_t state_q, state_d;
    sbc_sel_t asel;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;
    logic setup, wr_done, wr_sc1, wr_sc2, wr_wake;
    logic [7:0] rd_byte;
    logic release_method_bit_q, return_mode_bit_q, outen_q, release_method_bit_eff_q, release_method_bit_next;
    logic [1:0] wut_q;
    logic xen_q, lf_osc_enable_q, clk_sel_q, clk_active_q, idle_q, timing_gen_halt_bit_q;
    logic [3:0] key_en_q;
    logic osc_reset_q, bad_osc;
    logic stop_m_q, stop_s_q, stop_d_q, stop_rise;
    logic [3:0] key_m_q, key_s_q;
    logic rel_lvl, stop_go, warm_done;
    logic [17:0] cnt_q, cnt_d;
    logic hf_q, lf_q, core_halt_q, presc_clr_q;

    assign asel = decode(paddr);
    assign setup = psel && !penable;
    assign wr_done = psel && penable && pready_q && pwrite;
    assign wr_sc1 = wr_done && (asel == SBC_SEL_SC1);
    assign wr_sc2 = wr_done && (asel == SBC_SEL_SC2);
    assign wr_wake = wr_done && (asel == SBC_SEL_WAKE);

    // ==========================================================
    // APB slave: one wait-free access phase, answer prepared in setup
    always_comb begin
        case (asel)
            // Undefined bits read as zero
            SBC_SEL_SC1: rd_byte = {state_q != SBC_RUN, release_method_bit_q, return_mode_bit_q, outen_q, wut_q, 2'h0};
            SBC_SEL_SC2: rd_byte = {xen_q, lf_osc_enable_q, clk_active_q, idle_q, 1'b0, timing_gen_halt_bit_q, 2'h0};
            SBC_SEL_WAKE: rd_byte = {4'h0, key_en_q};
            SBC_SEL_STAT: rd_byte = {4'h0, release_method_bit_eff_q, osc_reset_q, state_q == SBC_WARM, state_q == SBC_STOP};
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup && (asel == SBC_SEL_NONE);
            prdata_q <= (setup && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    // ==========================================================
    // Wake input synchronisers; first stage feeds only the second
    always_ff @(posedge clk) begin
        if (reset) begin
            stop_m_q <= 1'b0;
            stop_s_q <= 1'b0;
            stop_d_q <= 1'b0;
        end else begin
            stop_m_q <= stop_pin_port_n;
            stop_s_q <= stop_m_q;
            stop_d_q <= stop_s_q;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_key_sync
            always_ff @(posedge clk) begin
                if (reset) begin
                    key_m_q[gi] <= 1'b1;
                    key_s_q[gi] <= 1'b1;
                end else begin
                    key_m_q[gi] <= key_wakeup_inputs[gi];
                    key_s_q[gi] <= key_m_q[gi];
                end
            end
        end
    endgenerate

    assign stop_rise = stop_s_q && !stop_d_q;
    // Keys count only in level mode; edge mode looks at the stop pin alone
    assign rel_lvl = stop_s_q || |(key_en_q & ~key_s_q);

    // ==========================================================
    // system_control_first and wakeup control
    always_ff @(posedge clk) begin
        if (reset) begin
            release_method_bit_q <= SC1_RESET[SC1_RELEASE_METHOD_BIT];
            return_mode_bit_q <= SC1_RESET[SC1_RETURN_MODE_BIT];
            outen_q <= SC1_RESET[SC1_OUTEN];
            wut_q <= SC1_RESET[SC1_WUT_LSB +: 2];
        end else if (wr_sc1) begin
            release_method_bit_q <= pwdata[SC1_RELEASE_METHOD_BIT];
            return_mode_bit_q <= pwdata[SC1_RETURN_MODE_BIT];
            outen_q <= pwdata[SC1_OUTEN];
            wut_q <= pwdata[SC1_WUT_LSB +: 2];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            key_en_q <= WAKE_RESET;
        end else if (wr_wake) begin
            key_en_q <= pwdata[3:0];
        end
    end

    // Going to level mode waits for a stop pin rise; edge mode is immediate
    always_comb begin
        release_method_bit_next = wr_sc1 ? pwdata[SC1_RELEASE_METHOD_BIT] : release_method_bit_q;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            release_method_bit_eff_q <= 1'b0;
        end else if (!release_method_bit_next) begin
            release_method_bit_eff_q <= 1'b0;
        end else if (stop_rise) begin
            release_method_bit_eff_q <= 1'b1;
        end
    end

    assign stop_go = wr_sc1 && pwdata[SC1_STOP] && (state_q == SBC_RUN);

    // ==========================================================
    // Deep-stop sequencer
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            SBC_RUN: begin
                if (stop_go) begin
                    if (release_method_bit_eff_q && release_method_bit_next && rel_lvl) begin
                        state_d = SBC_WARM;
                        cnt_d = warm_len(pwdata[SC1_WUT_LSB +: 2]);
                    end else begin
                        // Edge mode stops even when the pin already stands high
                        state_d = SBC_STOP;
                    end
                end
            end
            SBC_STOP: begin
                if (release_method_bit_eff_q ? rel_lvl : stop_rise) begin
                    state_d = SBC_WARM;
                    cnt_d = warm_len(wut_q);
                end
            end
            SBC_WARM: begin
                // Only the counter ends warm-up; the pin is not looked at
                if (cnt_q == 18'h00001) begin
                    state_d = SBC_RUN;
                end
                cnt_d = cnt_q - 18'h00001;
            end
            default: begin
                state_d = SBC_RUN;
            end
        endcase
    end

    assign warm_done = (state_q == SBC_WARM) && (cnt_q == 18'h00001);

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= SBC_RUN;
            cnt_q <= 18'h00000;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // Core stays frozen, so its program counter and latches hold, until warm-up ends
    always_ff @(posedge clk) begin
        if (reset) begin
            core_halt_q <= 1'b0;
            presc_clr_q <= 1'b0;
        end else begin
            core_halt_q <= state_d != SBC_RUN;
            presc_clr_q <= stop_go;
        end
    end

    // ==========================================================
    // clock_and_standby_control
    assign bad_osc = (!pwdata[SC2_XEN] && !pwdata[SC2_LF_OSC_ENABLE]) || (!pwdata[SC2_XEN] && !pwdata[SC2_MAIN_CLOCK_SELECT])
        || (!pwdata[SC2_LF_OSC_ENABLE] && pwdata[SC2_MAIN_CLOCK_SELECT]);

    always_ff @(posedge clk) begin
        if (reset) begin
            xen_q <= SC2_RESET[SC2_XEN];
            lf_osc_enable_q <= SC2_RESET[SC2_LF_OSC_ENABLE];
            clk_sel_q <= SC2_RESET[SC2_MAIN_CLOCK_SELECT];
        end else if (warm_done) begin
            // Slow return keeps only the low-frequency oscillator
            xen_q <= !return_mode_bit_q;
            lf_osc_enable_q <= lf_osc_enable_q || return_mode_bit_q;
            clk_sel_q <= return_mode_bit_q;
        end else if (wr_sc2) begin
            xen_q <= pwdata[SC2_XEN];
            lf_osc_enable_q <= pwdata[SC2_LF_OSC_ENABLE];
            clk_sel_q <= pwdata[SC2_MAIN_CLOCK_SELECT];
        end
    end

    // A software write wins over a release arriving in the same cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            idle_q <= SC2_RESET[SC2_IDLE];
            timing_gen_halt_bit_q <= SC2_RESET[SC2_TIMING_GEN_HALT_BIT];
        end else begin
            if (wr_sc2) begin
                idle_q <= pwdata[SC2_IDLE];
            end else if (idle_release) begin
                idle_q <= 1'b0;
            end
            if (wr_sc2) begin
                timing_gen_halt_bit_q <= pwdata[SC2_TIMING_GEN_HALT_BIT];
            end else if (tg_release) begin
                timing_gen_halt_bit_q <= 1'b0;
            end
        end
    end

    // Monitor follows the select only while clocks run
    always_ff @(posedge clk) begin
        if (reset) begin
            clk_active_q <= 1'b0;
        end else if (state_q == SBC_RUN) begin
            clk_active_q <= clk_sel_q;
        end
    end

    // Held until the system reset that it asks for arrives
    always_ff @(posedge clk) begin
        if (reset) begin
            osc_reset_q <= 1'b0;
        end else if (wr_sc2 && bad_osc) begin
            osc_reset_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            hf_q <= 1'b1;
            lf_q <= 1'b0;
        end else begin
            case (state_d)
                SBC_STOP: begin
                    hf_q <= 1'b0;
                    lf_q <= 1'b0;
                end
                SBC_WARM: begin
                    hf_q <= !return_mode_bit_q;
                    lf_q <= lf_osc_enable_q || return_mode_bit_q;
                end
                default: begin
                    // On resume the new enables are not yet registered; take them directly to avoid a glitch
                    hf_q <= warm_done ? !return_mode_bit_q : xen_q;
                    lf_q <= warm_done ? (lf_osc_enable_q || return_mode_bit_q) : lf_osc_enable_q;
                end
            endcase
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign hf_osc_enable = hf_q;
    assign lf_osc_enable = lf_q;
    assign main_clock_in_use = clk_active_q;
    assign cpu_halt = idle_q;
    assign wdt_halt = idle_q;
    assign timing_gen_halt = timing_gen_halt_bit_q;
    assign core_halt = core_halt_q;
    assign prescaler_clear = presc_clr_q;
    assign osc_reset_req = osc_reset_q;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_stop_req;
        stop_go && !(release_method_bit_eff_q && release_method_bit_next && rel_lvl);
    endsequence

    sequence s_skip_req;
        stop_go && release_method_bit_eff_q && release_method_bit_next && rel_lvl;
    endsequence

    sequence s_stopped;
        (state_q == SBC_STOP) && !hf_osc_enable && !lf_osc_enable && core_halt;
    endsequence

    a_reset_values: assert property ($past(reset)
        |-> hf_osc_enable && !cpu_halt && !timing_gen_halt && !core_halt)
        else $error("control register reset values wrong");
    a_bad_osc: assert property (wr_sc2 && bad_osc |=> osc_reset_req)
        else $error("illegal oscillator write gave no reset request");
    a_clk_monitor: assert property ((state_q == SBC_RUN) && wr_sc2 ##1 (state_q == SBC_RUN)
        |=> main_clock_in_use == $past(pwdata[SC2_MAIN_CLOCK_SELECT], 2))
        else $error("clock monitor does not follow select");
    a_idle_enter: assert property (wr_sc2 && pwdata[SC2_IDLE] |=> cpu_halt && wdt_halt)
        else $error("CPU halt not entered");
    a_tg_enter: assert property (wr_sc2 && pwdata[SC2_TIMING_GEN_HALT_BIT] |=> timing_gen_halt)
        else $error("timing generator halt not entered");
    a_rd_undef: assert property (setup && !pwrite && (asel == SBC_SEL_SC2)
        |=> prdata[3] == 1'b0 && prdata[1:0] == 2'h0)
        else $error("undefined bits not zero");
    a_idle_release: assert property (cpu_halt && idle_release && !wr_sc2 |=> !cpu_halt)
        else $error("CPU halt not cleared on release");
    a_tg_release: assert property (timing_gen_halt && tg_release && !wr_sc2 |=> !timing_gen_halt)
        else $error("timing generator halt not cleared on release");
    a_stop_enter: assert property (s_stop_req |=> s_stopped ##0 prescaler_clear)
        else $error("deep-stop entry wrong");
    a_stop_skip: assert property (s_skip_req |=> (state_q == SBC_WARM) && prescaler_clear)
        else $error("active release did not skip to warm-up");
    a_level_release: assert property ((state_q == SBC_STOP) && release_method_bit_eff_q && rel_lvl |=> state_q == SBC_WARM)
        else $error("level release missed");
    a_edge_release: assert property ((state_q == SBC_STOP) && !release_method_bit_eff_q && stop_rise |=> state_q == SBC_WARM)
        else $error("edge release missed");
    a_edge_hold: assert property ((state_q == SBC_STOP) && !release_method_bit_eff_q && !stop_rise |=> state_q == SBC_STOP)
        else $error("edge mode left deep-stop without a rise");
    a_warm_hold: assert property ((state_q == SBC_WARM) && !warm_done |=> (state_q == SBC_WARM) && core_halt)
        else $error("warm-up left early");
    a_warm_count: assert property ((state_q == SBC_WARM) && (cnt_q > 18'h00001)
        |=> cnt_q == $past(cnt_q) - 18'h00001)
        else $error("warm-up counter not counting");
    a_warm_end: assert property (warm_done |=> (state_q == SBC_RUN) && !core_halt)
        else $error("no resume after warm-up");
    a_release_method_bit_wait: assert property (!release_method_bit_eff_q && !stop_rise |=> !release_method_bit_eff_q)
        else $error("level mode active without stop pin rise");
    // The third stage still holds its reset value three cycles after reset, so skip that edge
    a_pin_sync: assert property (stop_rise && !$past(reset, 3)
        |-> $past(stop_pin_port_n, 2) && !$past(stop_pin_port_n, 3))
        else $error("stop pin edge not two stages late");
endmodule

// File: testbench/sbc_wake_pins.sv
// Model of the external stop pin and key inputs that wake the block
`timescale 1ns/100ps
// ============================================
// Wake pin driver
module sbc_wake_pins (
    input wire logic clk,
    input wire logic slow,
    input wire logic pin_req,
    input wire logic [3:0] key_req,
    output logic stop_pin_port_n = 1'b0,
    output logic [3:0] key_wakeup_inputs = 4'hF
);
    logic [1:0] lag_q = 2'h0;

    // A slow driver only moves its pins every fourth cycle, like a sluggish external circuit
    always_ff @(posedge clk) begin
        lag_q <= lag_q + 2'h1;
        if (!slow || lag_q == 2'h0) begin
            stop_pin_port_n <= pin_req;
            key_wakeup_inputs <= key_req; // Keys idle high, pulled low only in level release
        end
    end
endmodule

// File: testbench/sbc_standby_ctrl_tb.sv
// Self-checking bench for the standby mode control block
`timescale 1ns/100ps
// ============================================
// Bench top
module sbc_standby_ctrl_tb;
    import sbc_pkg::*;
    localparam int WARM = 3;
    logic clk, reset, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic idle_release, tg_release, slow, pin_req;
    logic [3:0] key_req, key_wakeup_inputs;
    logic stop_pin_port_n, hf, lf, in_use, cpu, wdt, tg, core, psc, osc;
    wire logic [8:0] outs;
    int errors, checked, cycles;

    assign outs = {hf, lf, in_use, cpu, wdt, tg, core, psc, osc};

    sbc_wake_pins u_sbc_wake_pins (.clk(clk), .slow(slow), .pin_req(pin_req), .key_req(key_req),
        .stop_pin_port_n(stop_pin_port_n), .key_wakeup_inputs(key_wakeup_inputs));

    // Short warm-up counts keep the run brief
    sbc_standby_ctrl #(.WARM_CYC_00(18'h00008), .WARM_CYC_01(18'h00006), .WARM_CYC_10(18'h00004),
        .WARM_CYC_11(18'h00003)) u_sbc_standby_ctrl (.clk(clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .stop_pin_port_n(stop_pin_port_n),
        .key_wakeup_inputs(key_wakeup_inputs), .idle_release(idle_release), .tg_release(tg_release),
        .hf_osc_enable(hf), .lf_osc_enable(lf), .main_clock_in_use(in_use), .cpu_halt(cpu),
        .wdt_halt(wdt), .timing_gen_halt(tg), .core_halt(core), .prescaler_clear(psc),
        .osc_reset_req(osc));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ============================================
    // Shared tasks
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(logic wr, logic [7:0] a, logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // Only the bench timeout ends a wait for the slave
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(string what, logic [7:0] a, logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, exp, rd);
    endtask

    task automatic settle(int n, logic [8:0] exp);
        repeat (n) @(posedge clk);
        check("outs", 32'(exp), 32'(outs));
    endtask

    task automatic pulse(logic i_rel, logic t_rel);
        @(posedge clk);
        idle_release <= i_rel;
        tg_release <= t_rel;
        @(posedge clk);
        idle_release <= 1'b0;
        tg_release <= 1'b0;
    endtask

    task automatic wait_run(int lim);
        int n;
        n = 0;
        while (core !== 1'b0 && n < lim) begin
            n++;
            @(posedge clk);
        end
        check("core_halt", 32'h0, 32'(core));
    endtask

    task automatic do_reset;
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
    endtask

    // ============================================
    // Scenarios
    task automatic t_reset_vals;
        settle(1, 9'h100);
        rd_chk("ctl", ADDR_CLK_STBY, 32'h80);
        rd_chk("sc1", ADDR_SYS_CTRL1, 32'h0);
        rd_chk("wake", ADDR_WAKE_CTRL, 32'h0);
        apb(1'b1, 8'hF0, 32'hFF);
        check("slverr", 32'h1, 32'(err));
        rd_chk("unmapped", 8'hF0, 32'h0);
    endtask

    task automatic t_clock_sel;
        apb(1'b1, ADDR_CLK_STBY, 32'hE0);
        settle(3, 9'h1C0);
        rd_chk("ctl", ADDR_CLK_STBY, 32'hE0);
        apb(1'b1, ADDR_CLK_STBY, 32'hC0);
        settle(3, 9'h180);
        apb(1'b1, ADDR_CLK_STBY, 32'h80);
        settle(3, 9'h100);
    endtask

    task automatic t_halts;
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, ADDR_CLK_STBY, (i == 1) ? 32'h84 : 32'h90);
            settle(2, (i == 1) ? 9'h108 : 9'h130);
            // The other mode's release must leave this halt bit alone
            pulse(i == 1, i == 0);
            settle(2, (i == 1) ? 9'h108 : 9'h130);
            pulse(i == 0, i == 1);
            settle(2, 9'h100);
            rd_chk("ctl", ADDR_CLK_STBY, 32'h80);
        end
    endtask

    task automatic t_edge_stop;
        int n;
        n = 0;
        pin_req <= 1'b1;
        repeat (6) @(posedge clk);
        apb(1'b1, ADDR_SYS_CTRL1, 32'h8C);
        repeat (4) begin
            @(posedge clk);
            n += 32'(psc);
        end
        check("psc_pulses", 32'h1, 32'(n));
        settle(10, 9'h004);
        rd_chk("status", ADDR_STATUS, 32'h1);
        slow <= 1'b1;
        pin_req <= 1'b0;
        repeat (12) @(posedge clk);
        pin_req <= 1'b1;
        n = 0;
        while (hf !== 1'b1 && n < 40) begin
            n++;
            @(posedge clk);
        end
        n = 0;
        while (core === 1'b1 && n < 20) begin
            n++;
            @(posedge clk);
        end
        check("warm_len", 32'(WARM), 32'(n));
        slow <= 1'b0;
        settle(2, 9'h100);
        rd_chk("sc1", ADDR_SYS_CTRL1, 32'h0C);
    endtask

    task automatic t_level;
        apb(1'b1, ADDR_SYS_CTRL1, 32'h4C);
        rd_chk("status", ADDR_STATUS, 32'h0);
        pin_req <= 1'b0;
        repeat (6) @(posedge clk);
        pin_req <= 1'b1;
        repeat (6) @(posedge clk);
        rd_chk("status", ADDR_STATUS, 32'h8);
        // Longest warm-up, so the pin falls while warm-up still runs
        apb(1'b1, ADDR_SYS_CTRL1, 32'hC0);
        pin_req <= 1'b0;
        settle(1, 9'h106);
        wait_run(20);
        settle(6, 9'h100);
        apb(1'b1, ADDR_WAKE_CTRL, 32'h2);
        // Slow return: only the low-frequency oscillator comes back, select moves to it
        apb(1'b1, ADDR_SYS_CTRL1, 32'hEC);
        settle(2, 9'h004);
        key_req <= 4'hE;
        settle(8, 9'h004);
        key_req <= 4'hD;
        wait_run(30);
        settle(2, 9'h0C0);
        key_req <= 4'hF;
    endtask

    task automatic t_resets;
        logic [31:0] pre[3] = '{32'h80, 32'h80, 32'hE0};
        logic [31:0] bad[3] = '{32'h00, 32'h40, 32'hA0};
        for (int i = 0; i < 3; i++) begin
            do_reset();
            apb(1'b1, ADDR_CLK_STBY, pre[i]);
            repeat (2) @(posedge clk);
            check("osc_req", 32'h0, 32'(osc));
            apb(1'b1, ADDR_CLK_STBY, bad[i]);
            repeat (2) @(posedge clk);
            check("osc_req", 32'h1, 32'(osc));
        end
        do_reset();
        apb(1'b1, ADDR_SYS_CTRL1, 32'hA0);
        settle(2, 9'h004);
        do_reset();
        settle(1, 9'h100);
        rd_chk("sc1", ADDR_SYS_CTRL1, 32'h0);
    endtask

    task automatic tally_and_finish;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ============================================
    // Timeout and main sequence
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            tally_and_finish();
        end
    end

    initial begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        idle_release = 1'b0;
        tg_release = 1'b0;
        slow = 1'b0;
        pin_req = 1'b0;
        key_req = 4'hF;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        t_reset_vals();
        t_clock_sel();
        t_halts();
        t_edge_stop();
        t_level();
        t_resets();
        tally_and_finish();
    end
endmodule
